/* File: rtl/dsp_fifo.sv */
// Purpose: Small synchronous FIFO with registered head word
// Assumes: Depth is a power of two
// Notes: Write while full is refused through wready
`default_nettype none
module dsp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  dsp_fifo_if.fifo_side f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW-1:0] rptr_d;
  logic [AW:0] cnt_q;
  logic [W-1:0] head_q;
  logic wr;
  logic rd;
  assign f.wready = (cnt_q != (AW+1)'(DEPTH));
  assign f.rvalid = (cnt_q != '0);
  assign f.rdata = head_q;
  assign wr = f.wvalid && f.wready;
  assign rd = f.rready && f.rvalid;
  assign rptr_d = rd ? rptr_q + 1'b1 : rptr_q;
  always_ff @(posedge sys_clk) begin
    if (wr) begin
      mem_q[wptr_q] <= f.wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      head_q <= '0;
    end else begin
      if (wr) begin
        wptr_q <= wptr_q + 1'b1;
      end
      rptr_q <= rptr_d;
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
      head_q <= (wr && wptr_q == rptr_d) ? f.wdata : mem_q[rptr_d];
    end
  end
endmodule : dsp_fifo
`default_nettype wire

/* File: rtl/dsp_fifo_if.sv */
// Purpose: Valid/ready carrier between a user and a FIFO
// Assumes: One writer and one reader
// Notes: Width is a parameter
`default_nettype none
interface dsp_fifo_if #(parameter int W = 8);
  logic [W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [W-1:0] rdata;
  logic rvalid;
  logic rready;
  modport fifo_side(input wdata, wvalid, rready, output wready, rdata, rvalid);
  modport user_side(output wdata, wvalid, rready, input wready, rdata, rvalid);
endinterface : dsp_fifo_if
`default_nettype wire

/* File: rtl/dsp_mode.sv */
// Purpose: Interface mode capture and online/offline tracking
// Assumes: Mode switch is synchronous to the clock
// Notes: Sample is high in the first cycle after reset release
`default_nettype none
module dsp_mode import dsp_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] mode_sw,
  output logic sample,
  output logic online,
  output logic offline,
  output logic from_online,
  output logic line_test,
  output logic ram_check,
  output logic inspect
);
  logic armed_q;
  logic [3:0] boot_q;
  logic online_q;
  logic offline_q;
  logic from_q;
  assign sample = !armed_q && !rst;
  assign online = online_q;
  assign offline = offline_q;
  assign from_online = from_q;
  assign line_test = armed_q && boot_q == DSP_MODE_LINE_TEST; // R14
  assign ram_check = armed_q && boot_q == DSP_MODE_RAM_CHECK; // R14
  assign inspect = armed_q && boot_q == DSP_MODE_INSPECT; // R14
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      armed_q <= 1'b0;
      boot_q <= '0;
    end else begin
      armed_q <= 1'b1;
      if (sample) begin
        boot_q <= mode_sw; // R13
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      online_q <= 1'b0;
      offline_q <= 1'b0;
      from_q <= 1'b0;
    end else if (sample) begin
      online_q <= mode_sw <= DSP_MODE_ONLINE_LAST; // R14
      offline_q <= mode_sw == DSP_MODE_OFFLINE; // R16
      from_q <= 1'b0;
    end else if (online_q && mode_sw == DSP_MODE_OFFLINE) begin
      online_q <= 1'b0; // R15
      offline_q <= 1'b1;
      from_q <= 1'b1;
    end else if (from_q && mode_sw == boot_q) begin
      online_q <= 1'b1; // R15
      offline_q <= 1'b0;
      from_q <= 1'b0;
    end
  end
endmodule : dsp_mode
`default_nettype wire

/* File: rtl/dsp_pkg.sv */
// Operation
// R1: Three rate switches pick 600 to 19200 baud
// R2: Data-length switch picks seven or eight bits
// R3: Parity checked only when enabled; odd/even select
// R4: Stop bits one or two; XON/XOFF or DTR
// R5: XON/XOFF mode consumes received 11H and 13H
// R6: Peer keeps 11H/13H out of XON/XOFF payload
// R7: Send indicator toggles while sending, off after reset
// R8: Receive indicator toggles while receiving, off after reset
// R9: Full, parity, overrun/framing, access flags latch
// R10: Send-busy on while transmit buffer holds data
// R11: Receive-full asserts; further bytes dropped while full
// R12: Access error flagged when host exchange fails
// R13: Switches sampled only at reset release
// R14: Interface mode codes: online, offline, tests
// R15: Online start may drop offline and return
// R16: Offline start stays offline until reset
// R17: Offline terminal connects only to port B
// R18: Terminal connection forces automatic port B settings
// R19: Port A serves offline only after online start
// Purpose: Shared constants and types for the dual serial port block
// Assumes: Port A is the RS-232C side, port B the RS-422 side
// Notes: Switch bytes follow the front-panel switch order
`default_nettype none
package dsp_pkg;
  localparam int unsigned DSP_CLK_HZ = 40_000_000;
  localparam int DSP_DW = 8;
  localparam int DSP_FIFO_DEPTH = 8;
  localparam int DSP_DIV_W = 17;
  localparam logic [7:0] DSP_XON = 8'h11;
  localparam logic [7:0] DSP_XOFF = 8'h13;
  localparam logic [3:0] DSP_MODE_ONLINE_LAST = 4'h2;
  localparam logic [3:0] DSP_MODE_OFFLINE = 4'h3;
  localparam logic [3:0] DSP_MODE_LINE_TEST = 4'h8;
  localparam logic [3:0] DSP_MODE_RAM_CHECK = 4'h9;
  localparam logic [3:0] DSP_MODE_INSPECT = 4'hA;
  localparam int SW_DATA8 = 0;
  localparam int SW_RATE_LO = 1;
  localparam int SW_PAR_EN = 4;
  localparam int SW_PAR_EVEN = 5;
  localparam int SW_STOP2 = 6;
  localparam int SW_DTR = 7;
  localparam logic [7:0] DSP_SW_AUTO = 8'hAB;
  localparam logic [7:0] DSP_SW_RST = 8'h00;
  localparam logic [2:0] DSP_RATE_MIN = 3'h1;
  localparam logic [2:0] DSP_RATE_MAX = 3'h6;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} dsp_ser_t;
  function automatic int unsigned dsp_baud(input logic [2:0] code);
    unique case (code)
      3'h1: return 600;
      3'h2: return 1200;
      3'h3: return 2400;
      3'h4: return 4800;
      3'h5: return 9600;
      3'h6: return 19200;
      default: return 600;
    endcase
  endfunction : dsp_baud
  function automatic logic dsp_par(input logic [7:0] d, input logic even);
    return even ? ^d : ~^d;
  endfunction : dsp_par
endpackage : dsp_pkg
`default_nettype wire

/* File: rtl/dsp_top.sv */
// Purpose: Two asynchronous serial ports with switch setup and indicators
// Assumes: Host pushes and pops bytes over valid/ready ports
// Notes: Index 0 is port A (RS-232C), index 1 is port B (RS-422)
`default_nettype none
module dsp_top import dsp_pkg::*; #(
  parameter int unsigned CLK_HZ = DSP_CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] mode_sw,
  input wire logic [7:0] comm_sw_a,
  input wire logic [7:0] comm_sw_b,
  input wire logic prog_terminal_present,
  input wire logic [1:0] rxd,
  output logic [1:0] txd,
  input wire logic [1:0] peer_ready,
  output logic [1:0] dtr_out,
  input wire logic [1:0][7:0] host_tx_data,
  input wire logic [1:0] host_tx_valid,
  output logic [1:0] host_tx_ready,
  output logic [1:0][7:0] host_rx_data,
  output logic [1:0] host_rx_valid,
  input wire logic [1:0] host_rx_ready,
  output logic [1:0] rate_invalid,
  output logic online,
  output logic line_test,
  output logic ram_check,
  output logic inspect,
  output logic port_a_send_activity,
  output logic port_b_send_activity,
  output logic port_a_recv_activity,
  output logic port_b_recv_activity,
  output logic port_a_tx_buffer_busy,
  output logic port_b_tx_buffer_busy,
  output logic port_a_rx_buffer_full,
  output logic port_b_rx_buffer_full,
  output logic port_a_parity_error,
  output logic port_b_parity_error,
  output logic port_a_overrun_framing_error,
  output logic port_b_overrun_framing_error,
  output logic port_a_access_error,
  output logic port_b_access_error
);
  logic sample;
  logic offline;
  logic from_online;
  logic [7:0] sw_in [2];
  logic [1:0] port_on;
  logic [1:0] send_act;
  logic [1:0] recv_act;
  logic [1:0] busy;
  logic [1:0] rx_full;
  logic [1:0] par_err;
  logic [1:0] ovr_err;
  logic [1:0] acc_err;

  dsp_mode u_mode (
    .sys_clk(sys_clk),
    .rst(rst),
    .mode_sw(mode_sw),
    .sample(sample),
    .online(online),
    .offline(offline),
    .from_online(from_online),
    .line_test(line_test),
    .ram_check(ram_check),
    .inspect(inspect)
  );

  assign sw_in[0] = comm_sw_a;
  assign sw_in[1] = comm_sw_b;
  assign port_on[0] = online || (offline && from_online); // R19
  assign port_on[1] = online || (offline && prog_terminal_present); // R17

  function automatic logic [DSP_DIV_W-1:0] bit_div(input logic [2:0] code);
    int unsigned q;
    q = CLK_HZ / dsp_baud(code);
    return DSP_DIV_W'(q);
  endfunction : bit_div

  for (genvar p = 0; p < 2; p++) begin : g_port
    dsp_fifo_if #(.W(DSP_DW)) txf ();
    dsp_fifo_if #(.W(DSP_DW)) rxf ();
    logic [7:0] cfg;
    logic [7:0] sw_q;
    logic en;
    logic data8;
    logic par_en;
    logic xon_mode;
    logic [DSP_DIV_W-1:0] div;
    logic [2:0] last;
    logic tx_go;
    logic tx_tick;
    logic rx_tick;
    logic is_flow;
    logic host_fault;
    dsp_ser_t tst_q;
    dsp_ser_t rst_q;
    logic [DSP_DIV_W-1:0] tcnt_q;
    logic [DSP_DIV_W-1:0] rcnt_q;
    logic [2:0] tidx_q;
    logic [2:0] ridx_q;
    logic [7:0] tsh_q;
    logic [7:0] rsh_q;
    logic tpar_q;
    logic txd_q;
    logic rbad_par_q;
    logic rbad_frm_q;
    logic rdone_q;
    logic xoff_q;
    logic sact_q;
    logic ract_q;
    logic busy_q;
    logic full_q;
    logic perr_q;
    logic oerr_q;
    logic aerr_q;
    logic dtr_q;

    dsp_fifo #(.W(DSP_DW), .DEPTH(DSP_FIFO_DEPTH)) u_txf (
      .sys_clk(sys_clk),
      .rst(rst),
      .f(txf.fifo_side)
    );
    dsp_fifo #(.W(DSP_DW), .DEPTH(DSP_FIFO_DEPTH)) u_rxf (
      .sys_clk(sys_clk),
      .rst(rst),
      .f(rxf.fifo_side)
    );

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        sw_q <= DSP_SW_RST;
      end else if (sample) begin
        sw_q <= sw_in[p]; // R13
      end
    end

    if (p == 1) begin : g_auto
      assign cfg = (offline && prog_terminal_present) ? DSP_SW_AUTO : sw_q; // R18
    end else begin : g_man
      assign cfg = sw_q;
    end
    assign data8 = cfg[SW_DATA8]; // R2
    assign par_en = cfg[SW_PAR_EN]; // R3
    assign xon_mode = !cfg[SW_DTR]; // R4
    assign rate_invalid[p] = cfg[SW_RATE_LO+:3] < DSP_RATE_MIN
      || cfg[SW_RATE_LO+:3] > DSP_RATE_MAX; // R1
    assign en = port_on[p] && !rate_invalid[p];
    assign div = bit_div(cfg[SW_RATE_LO+:3]) - 1'b1; // R1
    assign last = data8 ? 3'h7 : 3'h6; // R2
    assign tx_go = xon_mode ? !xoff_q : peer_ready[p]; // R4
    assign tx_tick = tst_q != ST_IDLE && tcnt_q == '0;
    assign rx_tick = rst_q != ST_IDLE && rcnt_q == '0;

    assign txf.wdata = host_tx_data[p];
    assign txf.wvalid = host_tx_valid[p] && en;
    assign txf.rready = tst_q == ST_IDLE && en && tx_go;
    assign host_tx_ready[p] = txf.wready && en;
    assign host_rx_data[p] = rxf.rdata;
    assign host_rx_valid[p] = rxf.rvalid;
    assign rxf.rready = host_rx_ready[p];
    assign is_flow = xon_mode && (rsh_q == DSP_XON || rsh_q == DSP_XOFF); // R5
    assign rxf.wdata = rsh_q;
    assign rxf.wvalid = rdone_q && !is_flow; // R11
    assign host_fault = (host_tx_valid[p] && !host_tx_ready[p])
      || (host_rx_ready[p] && !rxf.rvalid);
    assign txd[p] = txd_q;

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        tst_q <= ST_IDLE;
        tcnt_q <= '0;
        tidx_q <= '0;
        tsh_q <= '0;
        tpar_q <= 1'b0;
        txd_q <= 1'b1;
      end else if (tst_q == ST_IDLE) begin
        txd_q <= 1'b1;
        if (txf.rready && txf.rvalid) begin
          tsh_q <= data8 ? txf.rdata : {1'b0, txf.rdata[6:0]}; // R2
          tpar_q <= dsp_par(data8 ? txf.rdata : {1'b0, txf.rdata[6:0]},
            cfg[SW_PAR_EVEN]); // R3
          txd_q <= 1'b0;
          tcnt_q <= div;
          tst_q <= ST_START;
        end
      end else if (!tx_tick) begin
        tcnt_q <= tcnt_q - 1'b1;
      end else begin
        tcnt_q <= div;
        unique case (tst_q)
          ST_START: begin
            txd_q <= tsh_q[0];
            tidx_q <= '0;
            tst_q <= ST_DATA;
          end
          ST_DATA: begin
            if (tidx_q == last) begin
              txd_q <= par_en ? tpar_q : 1'b1; // R3
              tst_q <= par_en ? ST_PAR : ST_STOP;
              tidx_q <= '0;
            end else begin
              txd_q <= tsh_q[tidx_q+1'b1];
              tidx_q <= tidx_q + 1'b1;
            end
          end
          ST_PAR: begin
            txd_q <= 1'b1;
            tst_q <= ST_STOP;
          end
          default: begin
            if (cfg[SW_STOP2] && tidx_q == '0) begin
              tidx_q <= 3'h1; // R4
            end else begin
              tst_q <= ST_IDLE;
            end
          end
        endcase
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        rst_q <= ST_IDLE;
        rcnt_q <= '0;
        ridx_q <= '0;
        rsh_q <= '0;
        rbad_par_q <= 1'b0;
        rbad_frm_q <= 1'b0;
        rdone_q <= 1'b0;
      end else begin
        rdone_q <= 1'b0;
        if (rst_q == ST_IDLE) begin
          if (en && !rxd[p]) begin
            rcnt_q <= div >> 1;
            rsh_q <= '0;
            rbad_par_q <= 1'b0;
            rst_q <= ST_START;
          end
        end else if (!rx_tick) begin
          rcnt_q <= rcnt_q - 1'b1;
        end else begin
          rcnt_q <= div;
          unique case (rst_q)
            ST_START: begin
              ridx_q <= '0;
              rst_q <= rxd[p] ? ST_IDLE : ST_DATA;
            end
            ST_DATA: begin
              rsh_q[ridx_q] <= rxd[p];
              ridx_q <= ridx_q + 1'b1;
              if (ridx_q == last) begin
                rst_q <= par_en ? ST_PAR : ST_STOP; // R3
              end
            end
            ST_PAR: begin
              rbad_par_q <= rxd[p] != dsp_par(rsh_q, cfg[SW_PAR_EVEN]); // R3
              rst_q <= ST_STOP;
            end
            default: begin
              rbad_frm_q <= !rxd[p];
              rdone_q <= 1'b1;
              rst_q <= ST_IDLE;
            end
          endcase
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst || !xon_mode) begin
        xoff_q <= 1'b0;
      end else if (rdone_q && rsh_q == DSP_XOFF) begin
        xoff_q <= 1'b1; // R5
      end else if (rdone_q && rsh_q == DSP_XON) begin
        xoff_q <= 1'b0; // R5
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        sact_q <= 1'b0;
        ract_q <= 1'b0;
      end else begin
        sact_q <= tst_q == ST_IDLE ? 1'b0 : sact_q ^ tx_tick; // R7
        ract_q <= rst_q == ST_IDLE ? 1'b0 : ract_q ^ rx_tick; // R8
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        busy_q <= 1'b0;
        dtr_q <= 1'b0;
      end else begin
        busy_q <= txf.rvalid || tst_q != ST_IDLE; // R10
        dtr_q <= en && (xon_mode || rxf.wready);
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        full_q <= 1'b0;
        perr_q <= 1'b0;
        oerr_q <= 1'b0;
        aerr_q <= 1'b0;
      end else begin
        if (!rxf.wready) begin
          full_q <= 1'b1; // R9 R11
        end
        if (rdone_q && rbad_par_q) begin
          perr_q <= 1'b1; // R9
        end
        if (rdone_q && (rbad_frm_q || (rxf.wvalid && !rxf.wready))) begin
          oerr_q <= 1'b1; // R9
        end
        if (host_fault) begin
          aerr_q <= 1'b1; // R12
        end
      end
    end

    assign send_act[p] = sact_q;
    assign recv_act[p] = ract_q;
    assign busy[p] = busy_q;
    assign rx_full[p] = full_q;
    assign par_err[p] = perr_q;
    assign ovr_err[p] = oerr_q;
    assign acc_err[p] = aerr_q;
    assign dtr_out[p] = dtr_q;
  end

  assign port_a_send_activity = send_act[0];
  assign port_b_send_activity = send_act[1];
  assign port_a_recv_activity = recv_act[0];
  assign port_b_recv_activity = recv_act[1];
  assign port_a_tx_buffer_busy = busy[0];
  assign port_b_tx_buffer_busy = busy[1];
  assign port_a_rx_buffer_full = rx_full[0];
  assign port_b_rx_buffer_full = rx_full[1];
  assign port_a_parity_error = par_err[0];
  assign port_b_parity_error = par_err[1];
  assign port_a_overrun_framing_error = ovr_err[0];
  assign port_b_overrun_framing_error = ovr_err[1];
  assign port_a_access_error = acc_err[0];
  assign port_b_access_error = acc_err[1];
endmodule : dsp_top
`default_nettype wire

/* File: test/dsp_peer.sv */
// Purpose: Serial equipment model for one port
// Assumes: Bit period in clock cycles is set by the bench
// Notes: Line idles high between frames
`default_nettype none
module dsp_peer (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 100ps;
  int bit_cyc = 50;
  int nbits = 8;
  bit par_en = 1'b0;
  bit par_even = 1'b0;
  logic [7:0] got[$];
  logic [7:0] v;
  initial rxd = 1'b1;
  task automatic bit_out(input logic b);
    rxd = b;
    repeat (bit_cyc) @(posedge sys_clk);
    #2;
  endtask : bit_out
  // Payload and flow codes only as the bench commands
  task automatic send(input logic [7:0] d, input bit bad);
    logic p;
    p = ^(nbits == 8 ? d : {1'b0, d[6:0]}) ^ !par_even ^ bad;
    @(posedge sys_clk);
    #2;
    bit_out(1'b0);
    for (int i = 0; i < nbits; i++) bit_out(d[i]);
    if (par_en) bit_out(p);
    bit_out(1'b1);
  endtask : send
  always begin
    @(negedge txd);
    v = 8'h00;
    repeat (bit_cyc / 2) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_cyc) @(posedge sys_clk);
      v[i] = txd;
    end
    repeat (bit_cyc * (par_en + 1)) @(posedge sys_clk);
    got.push_back(v);
  end
endmodule : dsp_peer
`default_nettype wire

/* File: test/dsp_top_chk.sv */
// Purpose: Port-level assertions for the dual serial port block
// Assumes: One clock, synchronous active-high reset
// Notes: Attached to every dsp_top by bind
`default_nettype none
module dsp_top_chk import dsp_pkg::*; #(
  parameter int unsigned CLK_HZ = DSP_CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] mode_sw,
  input wire logic [1:0] rxd,
  input wire logic [1:0] txd,
  input wire logic [1:0] host_tx_valid,
  input wire logic [1:0] host_tx_ready,
  input wire logic [1:0] host_rx_valid,
  input wire logic [1:0] host_rx_ready,
  input wire logic [1:0] rate_invalid,
  input wire logic online,
  input wire logic line_test,
  input wire logic ram_check,
  input wire logic inspect,
  input wire logic port_a_send_activity,
  input wire logic port_b_recv_activity,
  input wire logic port_a_tx_buffer_busy,
  input wire logic port_a_rx_buffer_full,
  input wire logic port_b_rx_buffer_full,
  input wire logic port_a_parity_error,
  input wire logic port_b_parity_error,
  input wire logic port_a_overrun_framing_error,
  input wire logic port_b_overrun_framing_error,
  input wire logic port_a_access_error,
  input wire logic port_b_access_error
);
  logic [7:0] flags;
  assign flags = {port_a_rx_buffer_full, port_b_rx_buffer_full, port_a_parity_error,
    port_b_parity_error, port_a_overrun_framing_error, port_b_overrun_framing_error,
    port_a_access_error, port_b_access_error};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence push_a;
    host_tx_valid[0] && host_tx_ready[0];
  endsequence
  sequence stall_a;
    host_tx_valid[0] && !host_tx_ready[0];
  endsequence
  reset_state_a: assert property ($fell(rst) |-> txd == 2'b11 && !online
    && flags == 8'h00 && !port_a_send_activity && !port_b_recv_activity && !port_a_tx_buffer_busy)
    else $error("Outputs not idle after reset");
  sticky_flags_a: assert property ((flags & $past(flags)) == $past(flags))
    else $error("Latched flag cleared");
  push_busy_a: assert property (push_a |-> ##2 port_a_tx_buffer_busy)
    else $error("Send busy missing after push");
  tx_idle_a: assert property (!port_a_tx_buffer_busy |-> txd[0])
    else $error("Line not idle while send buffer empty");
  tx_access_a: assert property (stall_a |=> port_a_access_error)
    else $error("Refused push not flagged");
  rx_access_a: assert property (host_rx_ready[1] && !host_rx_valid[1]
    |=> port_b_access_error)
    else $error("Empty pop not flagged");
  rate_refuse_a: assert property (rate_invalid[0] |-> !host_tx_ready[0])
    else $error("Disabled port accepts data");
  send_toggle_a: assert property ($fell(txd[0]) |-> ##[1:250] $changed(port_a_send_activity))
    else $error("Send indicator idle during frame");
  recv_toggle_a: assert property ($fell(rxd[1]) |-> ##[1:250] $changed(port_b_recv_activity))
    else $error("Receive indicator idle during frame");
  offline_go_a: assert property (online && mode_sw == DSP_MODE_OFFLINE |-> ##[1:4] !online)
    else $error("Offline switch ignored");
  boot_hold_a: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
    |-> $stable({line_test, ram_check, inspect}))
    else $error("Boot mode changed in operation");
endmodule : dsp_top_chk
bind dsp_top dsp_top_chk #(.CLK_HZ(CLK_HZ)) i_dsp_top_chk (
  .sys_clk(sys_clk), .rst(rst), .mode_sw(mode_sw), .rxd(rxd), .txd(txd),
  .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
  .host_rx_valid(host_rx_valid), .host_rx_ready(host_rx_ready),
  .rate_invalid(rate_invalid), .online(online), .line_test(line_test),
  .ram_check(ram_check), .inspect(inspect), .port_a_send_activity(port_a_send_activity),
  .port_b_recv_activity(port_b_recv_activity), .port_a_tx_buffer_busy(port_a_tx_buffer_busy),
  .port_a_rx_buffer_full(port_a_rx_buffer_full), .port_b_rx_buffer_full(port_b_rx_buffer_full),
  .port_a_parity_error(port_a_parity_error), .port_b_parity_error(port_b_parity_error),
  .port_a_overrun_framing_error(port_a_overrun_framing_error),
  .port_b_overrun_framing_error(port_b_overrun_framing_error),
  .port_a_access_error(port_a_access_error), .port_b_access_error(port_b_access_error)
);
`default_nettype wire

/* File: test/tb_dsp_top.sv */
// Purpose: Self-checking bench for the dual serial port block
// Assumes: Bit period shortened through CLK_HZ
// Notes: Port A is index 0, port B index 1
`default_nettype none
module tb_dsp_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] mode_sw = 4'h0;
  logic [7:0] comm_sw_a = 8'h00;
  logic [7:0] comm_sw_b = 8'h00;
  logic prog_terminal_present = 1'b0;
  logic [1:0] peer_ready = 2'b11;
  logic [1:0][7:0] host_tx_data = '0;
  logic [1:0] host_tx_valid = 2'b00;
  logic [1:0] host_rx_ready = 2'b00;
  wire [1:0] txd, dtr_out, host_tx_ready, host_rx_valid, rate_invalid;
  wire [1:0][7:0] host_rx_data;
  wire online, line_test, ram_check, inspect, rxd_a, rxd_b;
  wire [1:0] snd, rcv, tbusy, rfull, perr, oerr, aerr;
  int failures = 0;
  int num_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  dsp_top #(.CLK_HZ(960_000)) i_dsp_top (
    .sys_clk(sys_clk), .rst(rst), .mode_sw(mode_sw), .comm_sw_a(comm_sw_a),
    .comm_sw_b(comm_sw_b), .prog_terminal_present(prog_terminal_present),
    .rxd({rxd_b, rxd_a}), .txd(txd), .peer_ready(peer_ready), .dtr_out(dtr_out),
    .host_tx_data(host_tx_data), .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
    .host_rx_data(host_rx_data), .host_rx_valid(host_rx_valid), .host_rx_ready(host_rx_ready),
    .rate_invalid(rate_invalid), .online(online), .line_test(line_test),
    .ram_check(ram_check), .inspect(inspect),
    .port_a_send_activity(snd[0]), .port_b_send_activity(snd[1]),
    .port_a_recv_activity(rcv[0]), .port_b_recv_activity(rcv[1]),
    .port_a_tx_buffer_busy(tbusy[0]), .port_b_tx_buffer_busy(tbusy[1]),
    .port_a_rx_buffer_full(rfull[0]), .port_b_rx_buffer_full(rfull[1]),
    .port_a_parity_error(perr[0]), .port_b_parity_error(perr[1]),
    .port_a_overrun_framing_error(oerr[0]), .port_b_overrun_framing_error(oerr[1]),
    .port_a_access_error(aerr[0]), .port_b_access_error(aerr[1])
  );
  dsp_peer pa (.sys_clk(sys_clk), .txd(txd[0]), .rxd(rxd_a));
  dsp_peer pb (.sys_clk(sys_clk), .txd(txd[1]), .rxd(rxd_b));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  task automatic boot(input logic [3:0] m, input logic [7:0] a, b, input logic t);
    rst = 1'b1;
    mode_sw = m;
    comm_sw_a = a;
    comm_sw_b = b;
    prog_terminal_present = t;
    tick(3);
    rst = 1'b0;
    tick(3);
  endtask : boot
  task automatic push(input int p, input logic [7:0] d);
    tick(1);
    for (int n = 0; n < 2000 && host_tx_ready[p] !== 1'b1; n++) tick(1);
    host_tx_data[p] = d;
    host_tx_valid[p] = 1'b1;
    tick(1);
    host_tx_valid[p] = 1'b0;
  endtask : push
  task automatic pop(input int p, input logic [7:0] e);
    tick(1);
    for (int n = 0; n < 3000 && host_rx_valid[p] !== 1'b1; n++) tick(1);
    chk("rx_data", {1'b1, e}, {host_rx_valid[p], host_rx_data[p]});
    host_rx_ready[p] = 1'b1;
    tick(1);
    host_rx_ready[p] = 1'b0;
  endtask : pop
  task automatic wait_q(input int n, input bit b);
    for (int k = 0; k < 20000 && (b ? pb.got.size() : pa.got.size()) < n; k++) tick(1);
  endtask : wait_q
  task automatic end_sim;
    $display("Checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    #(60_000 * 25);
    failures++;
    end_sim();
  end
  initial begin
    for (int r = 0; r < 8; r++) begin
      boot(4'h0, {4'h8, r[2:0], 1'b1}, 8'h3C, 1'b0);
      chk("rate_invalid", r == 0 || r == 7, rate_invalid[0]);
    end
    for (int m = 0; m < 11; m++) begin
      boot(m[3:0], 8'h8D, 8'h3C, 1'b0);
      chk("mode", {m < 3, m == 8, m == 9, m == 10},
        {online, line_test, ram_check, inspect});
    end
    $display("Boot modes done");
    boot(4'h0, 8'h8D, 8'h3C, 1'b0);
    pb.nbits = 7;
    pb.par_en = 1'b1;
    pb.par_even = 1'b1;
    chk("indicators", 0, |{snd, rcv, tbusy, rfull, perr, oerr, aerr});
    push(0, 8'hA5);
    tick(1);
    chk("tx_busy", 1, tbusy[0]);
    wait_q(1, 1'b0);
    chk("tx_byte", 8'hA5, pa.got[0]);
    tick(60);
    chk("tx_busy", 0, tbusy[0]);
    pa.send(8'h3C, 1'b0);
    pop(0, 8'h3C);
    pb.send(dsp_pkg::DSP_XOFF, 1'b0);
    pb.send(dsp_pkg::DSP_XON, 1'b0);
    pb.send(8'h55, 1'b0);
    pop(1, 8'h55);
    tick(1);
    chk("rx_empty", 0, host_rx_valid[1]);
    host_rx_ready[1] = 1'b1;
    tick(1);
    host_rx_ready[1] = 1'b0;
    tick(1);
    chk("access", 9'h001, {aerr[0], aerr[1]});
    pb.send(8'h2A, 1'b1);
    tick(10);
    chk("parity", 9'h001, {perr[0], perr[1]});
    comm_sw_a = 8'h00;
    mode_sw = 4'h8;
    tick(4);
    chk("cfg_held", 0, rate_invalid[0] | line_test);
    mode_sw = 4'h3;
    tick(5);
    chk("offline", 0, online);
    mode_sw = 4'h1;
    tick(5);
    chk("still_off", 0, online);
    mode_sw = 4'h0;
    tick(5);
    chk("back_on", 1, online);
    for (int i = 0; i < 9; i++) pa.send(8'h40 + 8'(i), 1'b0);
    tick(10);
    chk("rx_full", 9'h006, {rfull[0], oerr[0], dtr_out[0]});
    for (int i = 0; i < 8; i++) pop(0, 8'h40 + 8'(i));
    tick(1);
    chk("rx_drop", 0, host_rx_valid[0]);
    $display("Online port tests done");
    boot(4'h0, 8'h8B, 8'h3C, 1'b0);
    pa.bit_cyc = 100;
    pa.got.delete();
    peer_ready[0] = 1'b0;
    for (int i = 0; i < 8; i++) push(0, 8'hC0 + 8'(i));
    tick(2);
    chk("tx_full", 0, host_tx_ready[0]);
    host_tx_valid[0] = 1'b1;
    tick(1);
    host_tx_valid[0] = 1'b0;
    tick(300);
    chk("tx_stall", 9'h100, {aerr[0], 8'(pa.got.size())});
    peer_ready[0] = 1'b1;
    wait_q(8, 1'b0);
    for (int i = 0; i < 8; i++) chk("tx_order", 8'hC0 + 8'(i), pa.got[i]);
    tick(150);
    chk("tx_drain", 0, tbusy[0]);
    $display("Send buffer test done");
    boot(4'h3, 8'h8D, 8'h00, 1'b1);
    pb.nbits = 8;
    pb.par_en = 1'b0;
    pb.bit_cyc = 100;
    pb.got.delete();
    chk("off_boot", 9'h002, {online, host_tx_ready[0], rate_invalid[1], dtr_out});
    pb.send(8'h5A, 1'b0);
    pop(1, 8'h5A);
    push(1, 8'hC3);
    wait_q(1, 1'b1);
    chk("auto_tx", 8'hC3, pb.got[0]);
    mode_sw = 4'h0;
    tick(5);
    chk("stay_off", 0, online);
    $display("Offline test done");
    end_sim();
  end
endmodule : tb_dsp_top
`default_nettype wire
